/* File: hw/rapt_pkg.sv */
// Constants for the rectifier-two / auxiliary PWM edge timing block.
// Assumes a 40 MHz system clock and byte-wide register access.
//
// What this block does
// - Rectifier-two rise time: high byte at rect2_rise_time_high, low nibble rect2_rise_setting[7:4].
// - Each edge time step is 5 ns per least significant bit.
// - Rectifier-two fall time: high byte at rect2_fall_time_high, low nibble rect2_fall_setting[7:4].
// - Auxiliary rise time: high byte at aux_rise_time_high, low nibble aux_rise_setting[7:4].
// - Auxiliary fall time: high byte at aux_fall_time_high, low nibble 0x5C[7:4].
// - Setting bit 3 set lets loop modulation shift that edge.
// - Setting bit 2 set moves edge later with rising modulation, else earlier.
// - Writes to 0x55..0x5D take effect only when latch bit is written.
// - Rectifier-two output held low while disable register bit 6 is set.
// - Auxiliary output held low while disable register bit 7 is set.
package rapt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int TIME_W = 12;

  // *******************************************
  // Register offsets
  // *******************************************
  localparam logic [7:0] OFF_RECT2_RISE_HI = 8'h55;
  localparam logic [7:0] OFF_RECT2_RISE_SET = 8'h56;
  localparam logic [7:0] OFF_RECT2_FALL_HI = 8'h57;
  localparam logic [7:0] OFF_RECT2_FALL_SET = 8'h58;
  localparam logic [7:0] OFF_AUX_RISE_HI = 8'h59;
  localparam logic [7:0] OFF_AUX_RISE_SET = 8'h5a;
  localparam logic [7:0] OFF_AUX_FALL_HI = 8'h5b;
  localparam logic [7:0] OFF_AUX_FALL_SET = 8'h5c;
  localparam logic [7:0] OFF_OUT_DISABLE = 8'h5d;
  localparam logic [7:0] OFF_FIRST = OFF_RECT2_RISE_HI;
  localparam int NUM_REGS = 9;

  // *******************************************
  // Field positions
  // *******************************************
  localparam int FLD_LOW_MSB = 7;
  localparam int FLD_LOW_LSB = 4;
  localparam int BIT_MOD_EN = 3;
  localparam int BIT_MOD_NEG = 2;
  localparam int BIT_GO = 0;
  localparam int BIT_RECT2_DIS = 6;
  localparam int BIT_AUX_DIS = 7;

  // *******************************************
  // Reset values
  // *******************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // *******************************************
  // Timing
  // *******************************************
  localparam int STEP_PS = 5000;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int STEPS_PER_CLK = CLK_PERIOD_PS / STEP_PS;
  localparam int PERIOD_STEPS_DEF = 4096;

endpackage

/* File: hw/rapt_chan_if.sv */
// Carries one output channel's settings and result between the
// register side and the edge comparator.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface rapt_chan_if
  import rapt_pkg::*;
();
  logic        [7:0]        rise_hi;
  logic        [7:0]        rise_set;
  logic        [7:0]        fall_hi;
  logic        [7:0]        fall_set;
  logic                     disable_out;
  logic        [TIME_W-1:0] count;
  logic signed [TIME_W-1:0] modulation;
  logic                     drive;

  modport ctrl (
    output rise_hi, rise_set, fall_hi, fall_set,
    output disable_out, count, modulation,
    input  drive
  );

  modport chan (
    input  rise_hi, rise_set, fall_hi, fall_set,
    input  disable_out, count, modulation,
    output drive
  );
endinterface

/* File: hw/rapt_chan.sv */
// Edge comparator for one PWM output.
// Assumes the counter and settings arrive already latched.
`timescale 1ns/1ps
module rapt_chan
  import rapt_pkg::*;
(
  input  wire logic  sys_clk_in,
  input  wire logic  reset_in,
  rapt_chan_if.chan  ch
);

  logic [TIME_W-1:0] rise_eff;
  logic [TIME_W-1:0] fall_eff;
  logic              drive_reg;
  logic              drive_next;

  // *******************************************
  // Effective edge time
  // *******************************************
  function automatic logic [TIME_W-1:0] eff_time(
    input logic        [7:0]        hi,
    input logic        [7:0]        set,
    input logic signed [TIME_W-1:0] modv
  );
    logic signed [TIME_W+1:0] base;
    logic signed [TIME_W+1:0] sum;
    logic        [TIME_W-1:0] res;
    base = $signed({2'b00, hi, set[FLD_LOW_MSB:FLD_LOW_LSB]});
    sum  = base;
    if (set[BIT_MOD_EN]) begin
      if (set[BIT_MOD_NEG]) begin
        sum = base + (TIME_W+2)'(modv);
      end else begin
        sum = base - (TIME_W+2)'(modv);
      end
    end
    // Clamp keeps a large swing from wrapping round the 12-bit time range (0 to 4095), not the period
    if (sum < 0) begin
      res = '0;
    end else if (sum > $signed({2'b00, {TIME_W{1'b1}}})) begin
      res = '1;
    end else begin
      res = sum[TIME_W-1:0];
    end
    return res;
  endfunction

  assign rise_eff = eff_time(ch.rise_hi, ch.rise_set, ch.modulation);
  assign fall_eff = eff_time(ch.fall_hi, ch.fall_set, ch.modulation);

  // *******************************************
  // Window compare
  // *******************************************
  always_comb begin
    drive_next = 1'b0;
    if (rise_eff < fall_eff) begin
      drive_next = (ch.count >= rise_eff) && (ch.count < fall_eff);
    end else if (rise_eff > fall_eff) begin
      drive_next = (ch.count >= rise_eff) || (ch.count < fall_eff);
    end
    if (ch.disable_out) begin
      drive_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign ch.drive = drive_reg;

endmodule

/* File: hw/rapt_edge_timing.sv */
// Edge timing for the second rectifier drive and auxiliary PWM output.
// Holds software-visible and latched copies of the edge registers,
// runs the switching-period counter and feeds two edge comparators.
// Assumes the serial register interface presents one-cycle byte
// strobes synchronous to sys_clk_in.
`timescale 1ns/1ps
module rapt_edge_timing
  import rapt_pkg::*;
#(
  parameter int PERIOD_STEPS = PERIOD_STEPS_DEF
)(
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     reg_wr_en_in,
  input  wire logic                     reg_rd_en_in,
  input  wire logic        [ADDR_W-1:0] reg_addr_in,
  input  wire logic        [DATA_W-1:0] reg_wdata_in,
  input  wire logic signed [TIME_W-1:0] loop_mod_in,
  output logic             [DATA_W-1:0] reg_rdata_out,
  output logic                          reg_rvalid_out,
  output logic             [TIME_W-1:0] period_count_out,
  output logic                          rectifier_drive_two_out,
  output logic                          auxiliary_pwm_output_out
);

  localparam int CNT_W = TIME_W + 1;
  localparam logic [CNT_W-1:0] STEP_INC = CNT_W'(STEPS_PER_CLK);
  localparam logic [CNT_W-1:0] PERIOD_C = CNT_W'(PERIOD_STEPS);

  // *******************************************
  // Parameter check
  // *******************************************
  if (PERIOD_STEPS <= STEPS_PER_CLK ||
      PERIOD_STEPS > (1 << TIME_W)) begin : g_bad_period
    $error("PERIOD_STEPS out of range");
  end

  // *******************************************
  // Register state
  // *******************************************
  logic [DATA_W-1:0] shadow_reg [NUM_REGS];
  logic [DATA_W-1:0] shadow_next [NUM_REGS];
  logic [DATA_W-1:0] active_reg [NUM_REGS];
  logic [DATA_W-1:0] active_next [NUM_REGS];
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              in_range;
  logic [3:0]        reg_idx;
  logic              go_write;

  function automatic logic [3:0] off_to_idx(input logic [7:0] off);
    logic [7:0] d;
    d = off - OFF_FIRST;
    return d[3:0];
  endfunction

  assign in_range = (reg_addr_in >= OFF_FIRST) &&
                    (reg_addr_in <= OFF_OUT_DISABLE);
  assign reg_idx  = off_to_idx(reg_addr_in);
  assign go_write = reg_wr_en_in && (reg_addr_in == OFF_OUT_DISABLE) &&
                    reg_wdata_in[BIT_GO];

  // *******************************************
  // Register write and latch
  // *******************************************
  always_comb begin
    shadow_next = shadow_reg;
    active_next = active_reg;
    if (reg_wr_en_in && in_range) begin
      shadow_next[reg_idx] = reg_wdata_in;
      // Latch bit is a strobe, never stored
      if (reg_addr_in == OFF_OUT_DISABLE) begin
        shadow_next[reg_idx][BIT_GO] = 1'b0;
      end
    end
    // latch on trigger write
    // Same-cycle write is latched too, so one write can set the disable bits and go
    if (go_write) begin
      active_next = shadow_next;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        shadow_reg[i] <= RST_REG;
        active_reg[i] <= RST_REG;
      end
    end else begin
      shadow_reg <= shadow_next;
      active_reg <= active_next;
    end
  end

  // *******************************************
  // Register read
  // *******************************************
  always_comb begin
    rvalid_next = reg_rd_en_in;
    rdata_next  = rdata_reg;
    if (reg_rd_en_in) begin
      // Reads show the written values, not the latched ones
      rdata_next = in_range ? shadow_reg[reg_idx] : RST_RDATA;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg  <= RST_RDATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out  = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // *******************************************
  // Switching-period counter
  // *******************************************
  // advances 5 ns steps per clock
  // Edges land on whole 25 ns clocks; finer steps are quantised
  always_comb begin
    cnt_next = cnt_reg + STEP_INC;
    if (cnt_next >= PERIOD_C) begin
      cnt_next = cnt_next - PERIOD_C;
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign period_count_out = cnt_reg[TIME_W-1:0];

  // *******************************************
  // Output channels
  // *******************************************
  rapt_chan_if rect2_if ();
  rapt_chan_if aux_if ();

  assign rect2_if.rise_hi  = active_reg[off_to_idx(OFF_RECT2_RISE_HI)];
  assign rect2_if.rise_set = active_reg[off_to_idx(OFF_RECT2_RISE_SET)];
  assign rect2_if.fall_hi  = active_reg[off_to_idx(OFF_RECT2_FALL_HI)];
  assign rect2_if.fall_set = active_reg[off_to_idx(OFF_RECT2_FALL_SET)];
  assign rect2_if.disable_out =
    active_reg[off_to_idx(OFF_OUT_DISABLE)][BIT_RECT2_DIS];
  assign rect2_if.count      = cnt_reg[TIME_W-1:0];
  assign rect2_if.modulation = loop_mod_in;

  assign aux_if.rise_hi  = active_reg[off_to_idx(OFF_AUX_RISE_HI)];
  assign aux_if.rise_set = active_reg[off_to_idx(OFF_AUX_RISE_SET)];
  assign aux_if.fall_hi  = active_reg[off_to_idx(OFF_AUX_FALL_HI)];
  assign aux_if.fall_set = active_reg[off_to_idx(OFF_AUX_FALL_SET)];
  assign aux_if.disable_out =
    active_reg[off_to_idx(OFF_OUT_DISABLE)][BIT_AUX_DIS];
  assign aux_if.count      = cnt_reg[TIME_W-1:0];
  assign aux_if.modulation = loop_mod_in;

  rapt_chan u_rect2 (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .ch         (rect2_if.chan)
  );

  rapt_chan u_aux (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .ch         (aux_if.chan)
  );

  assign rectifier_drive_two_out  = rect2_if.drive;
  assign auxiliary_pwm_output_out = aux_if.drive;

endmodule

/* File: tb/rapt_edge_timing_props.sv */
// Checker for the rectifier-two / auxiliary edge timing block.
// Assumes it sees only the top module ports, bound below.
`timescale 1ns/1ps
module rapt_edge_timing_props
  import rapt_pkg::*;
#(
  parameter int PERIOD_STEPS = PERIOD_STEPS_DEF
)(
  input wire logic                     sys_clk_in,
  input wire logic                     reset_in,
  input wire logic                     reg_wr_en_in,
  input wire logic                     reg_rd_en_in,
  input wire logic        [ADDR_W-1:0] reg_addr_in,
  input wire logic        [DATA_W-1:0] reg_wdata_in,
  input wire logic signed [TIME_W-1:0] loop_mod_in,
  input wire logic        [DATA_W-1:0] reg_rdata_out,
  input wire logic                     reg_rvalid_out,
  input wire logic        [TIME_W-1:0] period_count_out,
  input wire logic                     rectifier_drive_two_out,
  input wire logic                     auxiliary_pwm_output_out
);
  // ***************************
  // Register mirror
  // ***************************
  logic [7:0] shadow_reg [NUM_REGS];
  logic [1:0] dis_reg;
  logic [7:0] exp_rd;
  logic       in_map;
  assign in_map = reg_addr_in >= OFF_FIRST && reg_addr_in <= OFF_OUT_DISABLE;
  always_comb begin
    exp_rd = 8'h00;
    if (in_map)
      exp_rd = shadow_reg[reg_addr_in - OFF_FIRST];
    if (reg_addr_in == OFF_OUT_DISABLE)
      exp_rd[BIT_GO] = 1'b0;
  end
  // Disable bits only count once latched
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      shadow_reg <= '{default: 8'h00};
      dis_reg <= 2'b00;
    end else if (reg_wr_en_in && in_map) begin
      shadow_reg[reg_addr_in - OFF_FIRST] <= reg_wdata_in;
      if (reg_addr_in == OFF_OUT_DISABLE && reg_wdata_in[BIT_GO])
        dis_reg <= reg_wdata_in[7:6];
    end
  end
  // ***************************
  // Assertions
  // ***************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  read_answer_a: assert property (reg_rd_en_in |=> reg_rvalid_out)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid_out |->
    $past(reg_rd_en_in)) else $error("read valid without read");
  read_data_a: assert property (reg_rd_en_in |=>
    reg_rdata_out == $past(exp_rd)) else $error("read data wrong");
  rdata_hold_a: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("read data moved");
  // First edge after release still sees the reset count as its past
  count_step_a: assert property (!$past(reset_in) |->
    int'(period_count_out) ==
    (int'($past(period_count_out)) + STEPS_PER_CLK) % PERIOD_STEPS)
    else $error("counter step wrong");
  count_range_a: assert property (int'(period_count_out) < PERIOD_STEPS)
    else $error("counter out of range");
  rect2_off_a: assert property (dis_reg[0] && $past(dis_reg[0])
    |-> !rectifier_drive_two_out) else $error("rect2 not held low");
  aux_off_a: assert property (dis_reg[1] && $past(dis_reg[1])
    |-> !auxiliary_pwm_output_out) else $error("aux not held low");
  cover property (reg_rd_en_in ##1 reg_rvalid_out);
  cover property ($rose(rectifier_drive_two_out));
  cover property ($rose(auxiliary_pwm_output_out));
endmodule

bind rapt_edge_timing rapt_edge_timing_props #(.PERIOD_STEPS(PERIOD_STEPS))
  u_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .loop_mod_in(loop_mod_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .period_count_out(period_count_out),
  .rectifier_drive_two_out(rectifier_drive_two_out),
  .auxiliary_pwm_output_out(auxiliary_pwm_output_out));

/* File: tb/rapt_gate_model.sv */
// Gate driver model: notes the counter value at each output edge.
// Assumes the outputs lag the counter by one clock.
`timescale 1ns/1ps
module rapt_gate_model
  import rapt_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic [TIME_W-1:0]     count_in,
  input  wire logic [1:0]            gate_in,
  output logic      [1:0][TIME_W-1:0] rise_at_out,
  output logic      [1:0][TIME_W-1:0] fall_at_out,
  output logic      [1:0][7:0]        rises_out
);
  logic [TIME_W-1:0] prev_reg;
  logic [1:0]        gate_reg;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_reg <= '0;
      gate_reg <= '0;
      rise_at_out <= '0;
      fall_at_out <= '0;
      rises_out <= '0;
    end else begin
      prev_reg <= count_in;
      gate_reg <= gate_in;
      for (int i = 0; i < 2; i++) begin
        if (gate_in[i] && !gate_reg[i]) begin
          rise_at_out[i] <= prev_reg;
          rises_out[i] <= rises_out[i] + 8'h01;
        end
        if (!gate_in[i] && gate_reg[i])
          fall_at_out[i] <= prev_reg;
      end
    end
  end
endmodule

/* File: tb/rapt_edge_timing_tb.sv */
// Testbench for the edge timing block, register tasks and scenarios.
// Assumes a short switching period so edges repeat every 40 clocks.
`timescale 1ns/1ps
module rapt_edge_timing_tb;
  import rapt_pkg::*;
  localparam int PSTEPS = 200;
  logic                     sys_clk_in = 1'b0;
  logic                     reset_in, wr_en, rd_en;
  logic        [7:0]        addr, wdata, rdata;
  logic signed [TIME_W-1:0] loop_mod;
  logic                     rvalid, rect2, aux;
  logic        [TIME_W-1:0] count;
  logic [1:0][TIME_W-1:0]   rise_at, fall_at;
  logic [1:0][7:0]          rises, old;
  int                       err_count, checks;
  always #12.5 sys_clk_in = ~sys_clk_in;
  rapt_edge_timing #(.PERIOD_STEPS(PSTEPS)) DUT (.sys_clk_in(sys_clk_in),
    .reset_in(reset_in), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .loop_mod_in(loop_mod),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .period_count_out(count), .rectifier_drive_two_out(rect2),
    .auxiliary_pwm_output_out(aux));
  rapt_gate_model u_gate (.clk_in(sys_clk_in), .reset_in(reset_in),
    .count_in(count), .gate_in({aux, rect2}), .rise_at_out(rise_at),
    .fall_at_out(fall_at), .rises_out(rises));
  // ***************************
  // Tasks
  // ***************************
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #2 {wr_en, addr, wdata} = {1'b1, a, d};
    @(posedge sys_clk_in);
    #2 wr_en = 1'b0;
  endtask
  // Read answer is registered on the taking edge and checked 2 ns later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    #2 {rd_en, addr} = {1'b1, a};
    @(posedge sys_clk_in);
    #2 rd_en = 1'b0;
    chk({11'h000, rvalid}, 12'h001);
    chk({4'h0, rdata}, {4'h0, exp});
  endtask
  task automatic edges(input logic [47:0] exp);
    repeat (100) @(posedge sys_clk_in);
    #2 chk(rise_at[0], exp[47:36]);
    chk(fall_at[0], exp[35:24]);
    chk(rise_at[1], exp[23:12]);
    chk(fall_at[1], exp[11:0]);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ***************************
  // Scenarios
  // ***************************
  initial begin
    {reset_in, wr_en, rd_en, addr, wdata, loop_mod} = {1'b1, 30'h0};
    {err_count, checks} = 0;
    repeat (4) @(posedge sys_clk_in);
    #2 reset_in = 1'b0;
    for (int i = 0; i < 9; i++) rd(8'(8'h55 + i), 8'h00);
    $display("Test reset values done");
    for (int i = 0; i < 9; i++) wr(8'(8'h55 + i), 8'(8'h34 + 8'h11 * i));
    wr(8'h3f, 8'hff);
    for (int i = 0; i < 9; i++) rd(8'(8'h55 + i), 8'(8'h34 + 8'h11 * i));
    rd(8'h3f, 8'h00);
    rd(8'h5e, 8'h00);
    $display("Test register access done");
    wr(8'h5d, 8'h00);
    wr(8'h55, 8'h01);
    wr(8'h56, 8'h40);
    wr(8'h57, 8'h03);
    wr(8'h58, 8'hc0);
    wr(8'h59, 8'h06);
    wr(8'h5a, 8'h40);
    wr(8'h5b, 8'h09);
    wr(8'h5c, 8'h60);
    repeat (100) @(posedge sys_clk_in);
    #2 chk({4'h0, rises[0] | rises[1]}, 12'h000);
    wr(8'h5d, 8'h01);
    edges({12'd20, 12'd60, 12'd100, 12'd150});
    $display("Test latched timing done");
    loop_mod = 12'sd10;
    wr(8'h56, 8'h44);
    wr(8'h58, 8'hc8);
    wr(8'h5a, 8'h4c);
    wr(8'h5c, 8'h68);
    wr(8'h5d, 8'h01);
    edges({12'd20, 12'd50, 12'd110, 12'd140});
    $display("Test modulation done");
    for (int k = 0; k < 2; k++) begin
      wr(8'h5d, k == 0 ? 8'h41 : 8'h81);
      repeat (3) @(posedge sys_clk_in);
      #2 old = rises;
      repeat (100) @(posedge sys_clk_in);
      #2 chk({4'h0, rises[k]}, {4'h0, old[k]});
      chk({11'h000, k == 0 ? rect2 : aux}, 12'h000);
      chk({11'h000, rises[1-k] != old[1-k]}, 12'h001);
    end
    $display("Test output disable done");
    finish_test();
  end
endmodule
